// ---- core/ulms_in_sync.v ----
// Three-stage synchroniser with agreement filter for the four modem inputs.
// Assumes asynchronous inputs and a single pclk domain.
`timescale 1ns/10ps
`include "ulms_map.vh"

module ulms_in_sync (
  input wire pclk,
  input wire presetn,
  input wire [3:0] async_in,
  output reg [3:0] sync_out
);

  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg [3:0] s3_q;

  // ========================================================================
  // Stage chain
  // The first stage feeds only the second; a change counts once the
  // second and third stages agree, so a metastable sample is never used.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= `ULMS_SYNC_IDLE;
      s2_q <= `ULMS_SYNC_IDLE;
      s3_q <= `ULMS_SYNC_IDLE;
      sync_out <= `ULMS_SYNC_IDLE;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q ^ s3_q));
    end
  end

endmodule

// ---- core/ulms_map.vh ----
// Register map, field positions and reset values for the line and modem
// status block. Assumes an APB slave with 32-bit data, one word a register.
`ifndef ULMS_MAP_VH
`define ULMS_MAP_VH

// ==========================================================================
// Register byte offsets
`define ULMS_OFF_LINE_STATUS 8'h00
`define ULMS_OFF_MODEM_STATUS 8'h04
`define ULMS_OFF_SCRATCH 8'h08
`define ULMS_OFF_MODEM_CONTROL 8'h0C
`define ULMS_OFF_RX_DATA 8'h10

// ==========================================================================
// Line status fields
`define ULMS_LS_READY 0
`define ULMS_LS_OVERRUN 1
`define ULMS_LS_PARITY 2
`define ULMS_LS_FRAMING 3
`define ULMS_LS_BREAK 4
`define ULMS_LS_THR_EMPTY 5
`define ULMS_LS_TX_EMPTY 6
`define ULMS_LS_FIFO_ERR 7

// ==========================================================================
// Modem control fields
`define ULMS_MC_DTR 0
`define ULMS_MC_RTS 1
`define ULMS_MC_OUT1 2
`define ULMS_MC_OUT2 3
`define ULMS_MC_LOOP 4

// ==========================================================================
// Sizes and reset values
`define ULMS_FIFO_DEPTH 16
`define ULMS_PTR_W 4
`define ULMS_CNT_W 5
`define ULMS_BYTE_ZERO 8'h00
`define ULMS_WORD_ZERO 32'h00000000
`define ULMS_CNT_ZERO 5'h00
`define ULMS_PTR_ZERO 4'h0
`define ULMS_PTR_ONE 4'h1
`define ULMS_CNT_ONE 5'h01
`define ULMS_CNT_FULL 5'h10
`define ULMS_NIB_ZERO 4'h0
`define ULMS_SYNC_IDLE 4'hF
`define ULMS_MC_ZERO 5'h00
`define ULMS_ENTRY_ZERO 11'h000

`endif

// ---- core/ulms_status.v ----
// Line status, modem status, scratch and modem control registers of one
// UART channel with a 16-deep receive holding FIFO, reached over APB.
// Assumes the receiver delivers one-cycle character strobes with error bits
// and that the modem inputs are asynchronous and active low.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "ulms_map.vh"

module ulms_status (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire fifo_mode,
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire rx_parity_bad,
  input wire rx_framing_bad,
  input wire rx_break,
  input wire tx_holding_empty,
  input wire tx_all_empty,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire cd_n,
  output wire modem_irq,
  output wire rts_n,
  output wire dtr_n,
  output wire user_output_one_n,
  output wire user_output_two_n,
  output wire rx_ready
);

  // ========================================================================
  // Declarations
  reg [7:0] scratch_q;
  reg [4:0] modem_control_q;
  reg [3:0] delta_q;
  reg [3:0] modem_prev_q;
  reg prev_valid_q;
  reg overrun_q;
  reg parity_q;
  reg framing_q;
  reg break_q;
  reg fifo_err_q;
  reg [10:0] mem_q [0:`ULMS_FIFO_DEPTH-1];
  reg [`ULMS_PTR_W-1:0] wr_ptr_q;
  reg [`ULMS_PTR_W-1:0] rd_ptr_q;
  reg [`ULMS_CNT_W-1:0] count_q;
  wire [3:0] modem_sync;
  wire [3:0] modem_live;
  wire [3:0] modem_now;
  wire [3:0] delta_hit;
  wire wr_access;
  wire rd_access;
  wire fifo_full;
  wire fifo_empty;
  wire push;
  wire pop;
  wire [10:0] head;
  wire ls_read;
  wire ms_read;
  wire [7:0] line_status;
  wire [7:0] modem_status;
  wire [7:0] ls_clear;
  integer i;

  // Decodes an offset to true when the access hits the given register.
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // ========================================================================
  // APB slave: zero wait states; unmapped addresses read zero, no error.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;
  assign ls_read = rd_access & hit(paddr, `ULMS_OFF_LINE_STATUS);
  assign ms_read = rd_access & hit(paddr, `ULMS_OFF_MODEM_STATUS);
  // A read clears only the flags it reported, so an event that lands
  // between the setup and access edges is kept for the next read.
  assign ls_clear = {8{ls_read}} & prdata[7:0];

  // ========================================================================
  // Modem input synchronisation; bit order CTS, DSR, RI, CD as active high.
  ulms_in_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({cd_n, ri_n, dsr_n, cts_n}),
    .sync_out(modem_sync)
  );

  assign modem_live = ~modem_sync;
  // Loop-back feeds the control bits back in place of the pins.
  assign modem_now = modem_control_q[`ULMS_MC_LOOP] ?
    {modem_control_q[`ULMS_MC_OUT2], modem_control_q[`ULMS_MC_OUT1],
     modem_control_q[`ULMS_MC_DTR], modem_control_q[`ULMS_MC_RTS]} :
    modem_live;

  // Order of delta bits: 0 CTS, 1 DSR, 2 RI, 3 CD.
  // The first sample after reset only seeds the history with the idle value,
  // so a CTS, DSR or CD input held active through reset still raises a change once synchronised.
  assign delta_hit[0] = prev_valid_q & (modem_now[0] ^ modem_prev_q[0]);
  assign delta_hit[1] = prev_valid_q & (modem_now[1] ^ modem_prev_q[1]);
  assign delta_hit[3] = prev_valid_q & (modem_now[3] ^ modem_prev_q[3]);
  // The ring pin going from 0 to 1 shows as its inverted status falling.
  assign delta_hit[2] = prev_valid_q & ~modem_now[2] & modem_prev_q[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delta_q <= `ULMS_NIB_ZERO;
      modem_prev_q <= `ULMS_NIB_ZERO;
      prev_valid_q <= 1'b0;
    end else begin
      modem_prev_q <= modem_now;
      prev_valid_q <= 1'b1;
      // A change seen in the read cycle, or one the read did not
      // report, survives the clear.
      delta_q <= (delta_q & ~(ms_read ? prdata[3:0] : `ULMS_NIB_ZERO)) |
                 delta_hit;
    end
  end

  assign modem_irq = |delta_q;
  assign modem_status = {modem_now[3], modem_now[2], modem_now[1],
                         modem_now[0], delta_q};

  // ========================================================================
  // Modem control outputs; pins are inactive high while looping back.
  assign dtr_n = modem_control_q[`ULMS_MC_LOOP] |
                 ~modem_control_q[`ULMS_MC_DTR];
  assign rts_n = modem_control_q[`ULMS_MC_LOOP] |
                 ~modem_control_q[`ULMS_MC_RTS];
  assign user_output_one_n = modem_control_q[`ULMS_MC_LOOP] |
                             ~modem_control_q[`ULMS_MC_OUT1];
  assign user_output_two_n = modem_control_q[`ULMS_MC_LOOP] |
                             ~modem_control_q[`ULMS_MC_OUT2];

  // ========================================================================
  // Receive holding FIFO: entry holds {break, framing, parity, data}.
  // In non-FIFO mode the depth is one, acting as a holding register.
  assign fifo_full = fifo_mode ? (count_q == `ULMS_CNT_FULL) :
                     (count_q != `ULMS_CNT_ZERO);
  assign fifo_empty = (count_q == `ULMS_CNT_ZERO);
  assign push = rx_char_valid & ~fifo_full;
  assign pop = rd_access & hit(paddr, `ULMS_OFF_RX_DATA) & ~fifo_empty;
  assign head = mem_q[rd_ptr_q];
  assign rx_ready = ~fifo_empty;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= `ULMS_PTR_ZERO;
      rd_ptr_q <= `ULMS_PTR_ZERO;
      count_q <= `ULMS_CNT_ZERO;
      for (i = 0; i < `ULMS_FIFO_DEPTH; i = i + 1) begin
        mem_q[i] <= `ULMS_ENTRY_ZERO;
      end
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= {rx_break, rx_framing_bad, rx_parity_bad,
                            rx_char};
        wr_ptr_q <= wr_ptr_q + `ULMS_PTR_ONE;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + `ULMS_PTR_ONE;
      end
      if (push & ~pop) begin
        count_q <= count_q + `ULMS_CNT_ONE;
      end else if (pop & ~push) begin
        count_q <= count_q - `ULMS_CNT_ONE;
      end
    end
  end

  // ========================================================================
  // Error flags. Framing and break are set while a flagged character sits at the head, and parity
  // too except in a FIFO-mode pop cycle; reading line status clears them, new events win.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
      parity_q <= 1'b0;
      framing_q <= 1'b0;
      break_q <= 1'b0;
      fifo_err_q <= 1'b0;
    end else begin
      overrun_q <= (overrun_q & ~ls_clear[`ULMS_LS_OVERRUN]) |
                   (rx_char_valid & fifo_full);
      parity_q <= (parity_q & ~ls_clear[`ULMS_LS_PARITY]) |
                  (~fifo_empty & head[8] &
                  (~fifo_mode | ~pop));
      framing_q <= (framing_q & ~ls_clear[`ULMS_LS_FRAMING]) |
                   (~fifo_empty & head[9]);
      break_q <= (break_q & ~ls_clear[`ULMS_LS_BREAK]) |
                 (~fifo_empty & head[10]);
      fifo_err_q <= (fifo_err_q & ~ls_clear[`ULMS_LS_FIFO_ERR]) |
                    (fifo_mode & push &
                     (rx_parity_bad | rx_framing_bad | rx_break));
    end
  end

  // Transmit-empty bits come from the transmitter, which resets them high.
  assign line_status = {fifo_err_q, tx_all_empty, tx_holding_empty,
                        break_q, framing_q, parity_q, overrun_q,
                        ~fifo_empty};

  // ========================================================================
  // Writes. Scratch has no effect on any other function.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_q <= `ULMS_BYTE_ZERO;
      modem_control_q <= `ULMS_MC_ZERO;
    end else if (wr_access) begin
      if (hit(paddr, `ULMS_OFF_SCRATCH)) begin
        scratch_q <= pwdata[7:0];
      end
      if (hit(paddr, `ULMS_OFF_MODEM_CONTROL)) begin
        modem_control_q <= pwdata[4:0];
      end
    end
  end

  // ========================================================================
  // Read data registered in the setup cycle, visible in the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ULMS_WORD_ZERO;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `ULMS_OFF_LINE_STATUS: prdata <= {24'h000000, line_status};
        `ULMS_OFF_MODEM_STATUS: prdata <= {24'h000000, modem_status};
        `ULMS_OFF_SCRATCH: prdata <= {24'h000000, scratch_q};
        `ULMS_OFF_MODEM_CONTROL: prdata <= {27'h0000000, modem_control_q};
        `ULMS_OFF_RX_DATA: prdata <= {24'h000000, head[7:0]};
        default: prdata <= `ULMS_WORD_ZERO;
      endcase
    end
  end

endmodule

// ---- verif/ulms_modem_model.sv ----
// Behavioural modem: drives the four active-low status lines.
// Assumes the bench commands line levels; lines idle high (inactive).
`timescale 1ns/10ps
module ulms_modem_model (
  input wire pclk,
  input wire [3:0] lines_n_cmd,
  output logic cts_n = 1'b1,
  output logic dsr_n = 1'b1,
  output logic ri_n = 1'b1,
  output logic cd_n = 1'b1
);
  // Lines change only at clock edges, well apart, so each is seen once.
  always @(posedge pclk) begin
    {cd_n, ri_n, dsr_n, cts_n} <= lines_n_cmd;
  end
endmodule

// ---- verif/ulms_status_checker.sv ----
// Concurrent checks on the ports of the line and modem status block.
// Assumes one pclk domain, APB reads latched at the setup edge.
`timescale 1ns/10ps
module ulms_status_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fifo_mode,
  input wire rx_char_valid,
  input wire rx_parity_bad,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire cd_n,
  input wire modem_irq,
  input wire rts_n,
  input wire dtr_n,
  input wire rx_ready
);
  // ========
  // Helpers
  wire rd_set = psel && !penable && !pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire idle = !psel && !rx_char_valid;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The bench reads one idle cycle after a push or an access.
  sequence s_bad_first;
    (rx_char_valid && rx_parity_bad && !rx_ready && !psel) ##1 idle
      ##1 (rd_set && paddr == 8'h00);
  endsequence
  sequence s_overrun;
    (!fifo_mode && rx_ready && rx_char_valid && !psel) ##1 idle
      ##1 (rd_set && paddr == 8'h00);
  endsequence
  sequence s_ls_twice;
    (rd_acc && paddr == 8'h00 && !rx_char_valid &&
     !$past(rx_char_valid)) ##1 idle
      ##1 (rd_set && paddr == 8'h00 && !rx_char_valid);
  endsequence
  sequence s_pop;
    (!fifo_mode && rd_set && paddr == 8'h10 && !rx_char_valid)
      ##1 (rd_acc && !rx_char_valid);
  endsequence
  // ========
  // Assertions
  a_zero_wait: assert property (pready && !pslverr)
    else $error("slave inserted wait or error");
  a_reset_quiet: assert property (
    $rose(presetn) |-> !modem_irq && !rx_ready && rts_n && dtr_n)
    else $error("outputs not quiet after reset");
  a_irq_flags: assert property (
    rd_acc && paddr == 8'h04 && (|prdata[3:0]) |-> modem_irq)
    else $error("change flag set without interrupt");
  a_ready_push: assert property (rx_char_valid |=> rx_ready)
    else $error("data ready missing after character");
  a_ready_mirror: assert property (
    rd_set && paddr == 8'h00 |=> prdata[0] == $past(rx_ready))
    else $error("ready bit differs from ready pin");
  a_pop_empty: assert property (s_pop |=> !rx_ready)
    else $error("ready stays after last character read");
  a_parity_head: assert property (s_bad_first |=> prdata[2])
    else $error("parity flag missing");
  a_overrun_set: assert property (s_overrun |=> prdata[1])
    else $error("overrun flag missing");
  a_overrun_clear: assert property (s_ls_twice |=> !prdata[1])
    else $error("overrun flag survives read");
  a_delta_irq: assert property (
    ($past(presetn) && ($changed(cts_n) || $changed(dsr_n) ||
      $changed(cd_n) || $rose(ri_n))) ##1 (!psel) [*8] |-> modem_irq)
    else $error("modem change raised no interrupt");
endmodule

bind ulms_status ulms_status_checker ulms_status_checker_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .fifo_mode, .rx_char_valid, .rx_parity_bad, .cts_n, .dsr_n,
  .ri_n, .cd_n, .modem_irq, .rts_n, .dtr_n, .rx_ready
);

// ---- verif/ulms_status_tb_top.sv ----
// Self-checking bench for the line and modem status block over APB.
// Assumes a zero-wait slave; transmit status inputs held empty.
`timescale 1ns/10ps
module ulms_status_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rx_char = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, modem_irq, rts_n, dtr_n, uo1_n, uo2_n, rx_ready;
  logic fifo_mode = 0, rx_char_valid = 0, rx_parity_bad = 0;
  logic [3:0] lines_n = 4'hF;
  logic [7:0] lb_exp [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
  wire cts_n, dsr_n, ri_n, cd_n;
  int num_errors = 0, samples_checked = 0;
  ulms_status ulms_status_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_mode, .rx_char_valid,
    .rx_char, .rx_parity_bad, .rx_framing_bad(1'b0), .rx_break(1'b0),
    .tx_holding_empty(1'b1), .tx_all_empty(1'b1), .cts_n, .dsr_n, .ri_n,
    .cd_n, .modem_irq, .rts_n, .dtr_n, .user_output_one_n(uo1_n),
    .user_output_two_n(uo2_n), .rx_ready);
  ulms_modem_model ulms_modem_model_inst (.pclk, .lines_n_cmd(lines_n),
    .cts_n, .dsr_n, .ri_n, .cd_n);
  initial forever #5 pclk = ~pclk;
  // ========
  // Tasks
  task test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // For a read, d is the expected word, compared under mask m.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
    if (!w) chk((prdata & m) === (d & m), "read data");
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h00000000);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    xfer(1'b0, a, d, m);
  endtask
  task push(input logic [7:0] d, input logic bad);
    @(posedge pclk);
    rx_char_valid <= 1'b1; rx_char <= d; rx_parity_bad <= bad;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
  endtask
  // ========
  // Scenarios
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h00000060, 32'hFFFFFFFF);
    rd(8'h04, 32'h00000000, 32'hFFFFFFFF);
    wr(8'h08, 32'h000000A5);
    rd(8'h08, 32'h000000A5, 32'hFFFFFFFF);
    rd(8'h00, 32'h00000060, 32'hFFFFFFFF);
    rd(8'h14, 32'h00000000, 32'hFFFFFFFF);
    // Ten cycles covers the synchroniser and change detection.
    for (int i = 0; i < 4; i++) begin
      lines_n[i] <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(modem_irq === (i != 2), "irq on assert");
      rd(8'h04, (32'h10 << i) | (i == 2 ? 32'h0 : 32'h1 << i), 32'hFF);
      rd(8'h04, 32'h10 << i, 32'hFF);
      lines_n[i] <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(modem_irq === 1'b1, "irq on release");
      rd(8'h04, 32'h1 << i, 32'hFF);
    end
    for (int v = 0; v < 4; v++) begin
      wr(8'h0C, 32'h10 | (32'h1 << v));
      rd(8'h04, {24'h0, lb_exp[v]}, 32'hF0);
      chk({rts_n, dtr_n, uo1_n, uo2_n} === 4'hF, "loop pins");
    end
    wr(8'h0C, 32'h0000000F);
    rd(8'h04, 32'h00000000, 32'hF0);
    chk({rts_n, dtr_n, uo1_n, uo2_n} === 4'h0, "control pins");
    wr(8'h0C, 32'h00000000);
    rd(8'h04, 32'h00000000, 32'hF0);
    push(8'h3C, 1'b1);
    rd(8'h00, 32'h00000005, 32'h07);
    push(8'hC3, 1'b0);
    rd(8'h00, 32'h00000003, 32'h03);
    rd(8'h00, 32'h00000001, 32'h03);
    rd(8'h10, 32'h0000003C, 32'hFF);
    rd(8'h00, 32'h00000000, 32'h01);
    fifo_mode <= 1'b1;
    push(8'h11, 1'b0);
    push(8'h22, 1'b1);
    rd(8'h00, 32'h00000080, 32'h84);
    rd(8'h10, 32'h00000011, 32'hFF);
    rd(8'h00, 32'h00000004, 32'h84);
    rd(8'h10, 32'h00000022, 32'hFF);
    for (int k = 0; k < 17; k++) push(k[7:0], 1'b0);
    rd(8'h00, 32'h00000003, 32'h03);
    for (int k = 0; k < 16; k++) rd(8'h10, k, 32'hFF);
    rd(8'h00, 32'h00000000, 32'h01);
    test_done();
  end
endmodule
